// ==== design/sdh_cfg.svh ====
`ifndef SDH_CFG_SVH
`define SDH_CFG_SVH
// ==========================================
// register offsets
`define SDH_OFS_CTRL   8'h00
`define SDH_OFS_DLEN   8'h04
`define SDH_OFS_DTMR   8'h08
`define SDH_OFS_DCNT   8'h0c
`define SDH_OFS_STS    8'h10
`define SDH_OFS_CLR    8'h14
`define SDH_OFS_BCNT   8'h18
`define SDH_OFS_FLOW   8'h1c
// ==========================================
// control field positions
`define SDH_B_GO       0
`define SDH_B_DIR      1
`define SDH_B_STREAM   2
`define SDH_B_DMA      3
`define SDH_B_BLK_LO   4
`define SDH_B_BLK_HI   7
`define SDH_B_RWBEGIN  8
`define SDH_B_RWHALT   9
`define SDH_B_RWSEL    10
`define SDH_B_CARD_IO_FUNCTION_EN     11
`define SDH_B_HFC      0
`define SDH_B_WIDE     1
// ==========================================
// status bit positions
`define SDH_S_DEND     8
`define SDH_S_SBERR    9
`define SDH_S_DTMO     3
`define SDH_S_RTMO     2
`define SDH_STICKY     23'h4007ff
// ==========================================
// reset values and counts
`define SDH_CTRL_RST   12'h000
`define SDH_BLK_RSVD   4'hf
`define SDH_RSP_TMO    7'h40
`define SDH_BUF_WORDS  6'h20
`define SDH_HALF_WORDS 6'h08
`define SDH_HFC_MARGIN 6'h02
`endif

// ==== design/sdh_data_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sdh_cfg.svh"
module sdh_data_ctrl (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // card pins
    input  wire logic        card_clk_in,
    input  wire logic [3:0]  card_data_in,
    output logic             data_line_two_out,
    output logic             data_line_two_oe,
    output logic             card_clock_hold,
    // data path and buffer
    input  wire logic        byte_strobe,
    input  wire logic        word_strobe,
    input  wire logic [5:0]  buf_level,
    input  wire logic        tx_underrun,
    input  wire logic        rx_overrun,
    input  wire logic        blk_crc_ok,
    input  wire logic        data_crc_fail,
    output logic             block_end,
    output logic             dma_request,
    output logic             card_io_mode,
    output logic             xfer_active,
    // command path events
    input  wire logic        cmd_active,
    input  wire logic        rsp_wait,
    input  wire logic        rsp_ok,
    input  wire logic        rsp_crc_fail,
    input  wire logic        cmd_sent,
    input  wire logic        card_irq
);
    // ==========================================
    // registers
    sdh_pkg::sdh_state_t state_r;
    logic [11:0] ctrl_r;
    logic [24:0] dlen_r;
    logic [31:0] dtmr_r;
    logic [31:0] tmo_cnt_r;
    logic [24:0] byte_cnt_r;
    logic [23:0] buf_cnt_r;
    logic [14:0] blk_cnt_r;
    logic [1:0]  flow_r;
    logic [22:0] sticky_r;
    logic [10:0] dyn_r;
    logic [6:0]  rsp_cnt_r;
    logic [2:0]  ck_s_r;
    logic        ck_lvl_r;
    logic [2:0]  d_s_r [4];
    logic [3:0]  d_lvl_r;
    logic [22:0] set_nxt;
    logic [31:0] rdata_nxt;
    logic [25:0] words_rnd;
    logic [14:0] blk_len;
    logic        ck_rise;
    logic        wr_ctrl;
    logic        wr_clr;
    logic        start;
    logic        rw_set;
    logic        done;
    logic        sbit_err;
    logic        tmo_hit;
    logic        tx_dir;
    logic        rx_dir;
    // ==========================================
    // pin synchronisers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ck_s_r   <= 3'h0;
            ck_lvl_r <= 1'b0;
        end else begin
            ck_s_r <= {ck_s_r[1:0], card_clk_in};
            if (ck_s_r[1] == ck_s_r[2]) begin
                ck_lvl_r <= ck_s_r[2];
            end
        end
    end
    assign ck_rise = (ck_s_r[1] == ck_s_r[2]) && ck_s_r[2] && !ck_lvl_r;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dsync
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    d_s_r[gi]   <= 3'h7;
                    d_lvl_r[gi] <= 1'b1;
                end else begin
                    d_s_r[gi] <= {d_s_r[gi][1:0], card_data_in[gi]};
                    if (d_s_r[gi][1] == d_s_r[gi][2]) begin
                        d_lvl_r[gi] <= d_s_r[gi][2];
                    end
                end
            end
        end
    endgenerate
    // ==========================================
    // decode
    assign wr_ctrl = reg_wr && (reg_addr == `SDH_OFS_CTRL);
    assign wr_clr  = reg_wr && (reg_addr == `SDH_OFS_CLR);
    assign start   = wr_ctrl && reg_wdata[`SDH_B_GO] && (state_r == sdh_pkg::SDH_IDLE);
    assign rw_set  = wr_ctrl && reg_wdata[`SDH_B_RWBEGIN] && !ctrl_r[`SDH_B_RWBEGIN];
    assign tx_dir  = !ctrl_r[`SDH_B_DIR];
    assign rx_dir  = ctrl_r[`SDH_B_DIR];
    assign done    = ((state_r == sdh_pkg::SDH_SEND) || (state_r == sdh_pkg::SDH_RECV))
                     && (byte_cnt_r == 25'h0);
    assign tmo_hit = (state_r == sdh_pkg::SDH_WAIT_R) && ck_rise && (tmo_cnt_r == 32'h0);
    assign sbit_err = (state_r == sdh_pkg::SDH_WAIT_R) && ck_rise && !d_lvl_r[0]
                      && flow_r[`SDH_B_WIDE] && (d_lvl_r != 4'h0);
    assign words_rnd = {1'b0, dlen_r} + 26'h3;
    assign blk_len = 15'h1 << ctrl_r[`SDH_B_BLK_HI:`SDH_B_BLK_LO];
    // ==========================================
    // control registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= `SDH_CTRL_RST;
            dlen_r <= 25'h0;
            dtmr_r <= 32'h0;
            flow_r <= 2'h0;
        end else if (reg_wr) begin
            if (reg_addr == `SDH_OFS_CTRL) begin
                ctrl_r <= reg_wdata[11:0];
            end
            if (reg_addr == `SDH_OFS_DLEN) begin
                dlen_r <= reg_wdata[24:0];
            end
            if (reg_addr == `SDH_OFS_DTMR) begin
                dtmr_r <= reg_wdata;
            end
            if (reg_addr == `SDH_OFS_FLOW) begin
                flow_r <= reg_wdata[1:0];
            end
        end
    end
    // ==========================================
    // data state machine
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= sdh_pkg::SDH_IDLE;
        end else begin
            case (state_r)
                sdh_pkg::SDH_IDLE: begin
                    if (start) begin
                        if (!reg_wdata[`SDH_B_DIR]) begin
                            state_r <= sdh_pkg::SDH_WAIT_S;
                        end else if (reg_wdata[`SDH_B_RWBEGIN]) begin
                            state_r <= sdh_pkg::SDH_RDWAIT;
                        end else begin
                            state_r <= sdh_pkg::SDH_WAIT_R;
                        end
                    end
                end
                sdh_pkg::SDH_WAIT_S: begin
                    if (buf_level != 6'h0) begin
                        state_r <= sdh_pkg::SDH_SEND;
                    end
                end
                sdh_pkg::SDH_WAIT_R: begin
                    if (rw_set) begin
                        state_r <= sdh_pkg::SDH_RDWAIT;
                    end else if (tmo_hit) begin
                        state_r <= sdh_pkg::SDH_IDLE;
                    end else if (ck_rise && !d_lvl_r[0]) begin
                        state_r <= sdh_pkg::SDH_RECV;
                    end
                end
                sdh_pkg::SDH_RDWAIT: begin
                    if (ctrl_r[`SDH_B_RWHALT] || !ctrl_r[`SDH_B_RWBEGIN]) begin
                        state_r <= sdh_pkg::SDH_WAIT_R;
                    end
                end
                sdh_pkg::SDH_SEND, sdh_pkg::SDH_RECV: begin
                    if (done) begin
                        state_r <= sdh_pkg::SDH_IDLE;
                    end
                end
                default: begin
                    state_r <= sdh_pkg::SDH_IDLE;
                end
            endcase
        end
    end
    // ==========================================
    // byte, word, block and timeout counters
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            byte_cnt_r <= 25'h0;
            buf_cnt_r  <= 24'h0;
        end else if (start) begin
            byte_cnt_r <= dlen_r;
            buf_cnt_r  <= words_rnd[25:2];
        end else begin
            if (byte_strobe && (byte_cnt_r != 25'h0)
                && ((state_r == sdh_pkg::SDH_SEND) || (state_r == sdh_pkg::SDH_RECV))) begin
                byte_cnt_r <= byte_cnt_r - 25'h1;
            end
            if (word_strobe && (buf_cnt_r != 24'h0)) begin
                buf_cnt_r <= buf_cnt_r - 24'h1;
            end
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            blk_cnt_r <= 15'h0;
            block_end <= 1'b0;
        end else begin
            block_end <= 1'b0;
            if (start) begin
                blk_cnt_r <= 15'h0;
            end else if (byte_strobe && !ctrl_r[`SDH_B_STREAM]
                         && (ctrl_r[`SDH_B_BLK_HI:`SDH_B_BLK_LO] != `SDH_BLK_RSVD)
                         && ((state_r == sdh_pkg::SDH_SEND)
                             || (state_r == sdh_pkg::SDH_RECV))) begin
                if (blk_cnt_r == blk_len - 15'h1) begin
                    blk_cnt_r <= 15'h0;
                    block_end <= 1'b1;
                end else begin
                    blk_cnt_r <= blk_cnt_r + 15'h1;
                end
            end
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tmo_cnt_r <= 32'h0;
        end else if (state_r != sdh_pkg::SDH_WAIT_R) begin
            tmo_cnt_r <= dtmr_r;
        end else if (ck_rise && (tmo_cnt_r != 32'h0)) begin
            tmo_cnt_r <= tmo_cnt_r - 32'h1;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_cnt_r <= 7'h0;
        end else if (!rsp_wait || rsp_ok || rsp_crc_fail) begin
            rsp_cnt_r <= 7'h0;
        end else if (ck_rise && (rsp_cnt_r != `SDH_RSP_TMO)) begin
            rsp_cnt_r <= rsp_cnt_r + 7'h1;
        end
    end
    // ==========================================
    // status flags
    always_comb begin
        set_nxt = 23'h0;
        set_nxt[0]  = rsp_crc_fail;
        set_nxt[1]  = data_crc_fail;
        set_nxt[`SDH_S_RTMO] = rsp_wait && ck_rise && !rsp_ok && !rsp_crc_fail
                               && (rsp_cnt_r == `SDH_RSP_TMO - 7'h1);
        set_nxt[`SDH_S_DTMO] = tmo_hit;
        set_nxt[4]  = tx_underrun;
        set_nxt[5]  = rx_overrun;
        set_nxt[6]  = rsp_ok;
        set_nxt[7]  = cmd_sent;
        set_nxt[`SDH_S_DEND]  = done;
        set_nxt[`SDH_S_SBERR] = sbit_err;
        set_nxt[10] = blk_crc_ok;
        set_nxt[22] = card_irq && ctrl_r[`SDH_B_CARD_IO_FUNCTION_EN];
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sticky_r <= 23'h0;
        end else begin
            sticky_r <= ((sticky_r & ~(wr_clr ? reg_wdata[22:0] : 23'h0))
                         | set_nxt) & `SDH_STICKY;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dyn_r <= 11'h0;
        end else begin
            dyn_r[10] <= rx_dir && (buf_level != 6'h0);
            dyn_r[9]  <= tx_dir && (buf_level != 6'h0);
            dyn_r[8]  <= rx_dir && (buf_level == 6'h0);
            dyn_r[7]  <= tx_dir && (flow_r[`SDH_B_HFC] ? (buf_level <= `SDH_HFC_MARGIN)
                                                      : (buf_level == 6'h0));
            dyn_r[6]  <= rx_dir && (flow_r[`SDH_B_HFC]
                         ? (buf_level >= `SDH_BUF_WORDS - `SDH_HFC_MARGIN)
                         : (buf_level == `SDH_BUF_WORDS));
            dyn_r[5]  <= tx_dir && (buf_level == `SDH_BUF_WORDS);
            dyn_r[4]  <= rx_dir && (buf_level >= `SDH_HALF_WORDS);
            dyn_r[3]  <= tx_dir && (`SDH_BUF_WORDS - buf_level >= `SDH_HALF_WORDS);
            dyn_r[2]  <= (state_r == sdh_pkg::SDH_WAIT_R) || (state_r == sdh_pkg::SDH_RECV)
                         || (state_r == sdh_pkg::SDH_RDWAIT);
            dyn_r[1]  <= (state_r == sdh_pkg::SDH_WAIT_S) || (state_r == sdh_pkg::SDH_SEND);
            dyn_r[0]  <= cmd_active;
        end
    end
    // ==========================================
    // pin and side outputs
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_line_two_out <= 1'b0;
            data_line_two_oe  <= 1'b0;
            card_clock_hold   <= 1'b0;
            dma_request       <= 1'b0;
            card_io_mode      <= 1'b0;
            xfer_active       <= 1'b0;
        end else begin
            data_line_two_out <= 1'b0;
            data_line_two_oe  <= (state_r == sdh_pkg::SDH_RDWAIT)
                                 && !ctrl_r[`SDH_B_RWSEL];
            card_clock_hold   <= (state_r == sdh_pkg::SDH_RDWAIT)
                                 && ctrl_r[`SDH_B_RWSEL];
            dma_request       <= ctrl_r[`SDH_B_DMA] && (dyn_r[4] || dyn_r[3]);
            card_io_mode      <= ctrl_r[`SDH_B_CARD_IO_FUNCTION_EN];
            xfer_active       <= (state_r != sdh_pkg::SDH_IDLE);
        end
    end
    // ==========================================
    // read port
    always_comb begin
        rdata_nxt = 32'h0;
        case (reg_addr)
            `SDH_OFS_CTRL: rdata_nxt = {20'h0, ctrl_r};
            `SDH_OFS_DLEN: rdata_nxt = {7'h0, dlen_r};
            `SDH_OFS_DTMR: rdata_nxt = dtmr_r;
            `SDH_OFS_DCNT: rdata_nxt = {7'h0, byte_cnt_r};
            `SDH_OFS_STS:  rdata_nxt = {9'h0, sticky_r[22], dyn_r, sticky_r[10:0]};
            `SDH_OFS_BCNT: rdata_nxt = {8'h0, buf_cnt_r};
            `SDH_OFS_FLOW: rdata_nxt = {30'h0, flow_r};
            default:       rdata_nxt = 32'h0;
        endcase
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : 32'h0;
        end
    end
    // ==========================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_start_load: assert property (start |=> byte_cnt_r == $past(dlen_r))
        else $error("byte counter not loaded");
    a_start_tx: assert property (start && !reg_wdata[1] |=> state_r == sdh_pkg::SDH_WAIT_S)
        else $error("tx start state");
    a_rdwait_direct: assert property (start && reg_wdata[1] && reg_wdata[8]
        |=> state_r == sdh_pkg::SDH_RDWAIT)
        else $error("read wait not entered");
    a_rdwait_halt: assert property (state_r == sdh_pkg::SDH_RDWAIT && ctrl_r[9]
        |=> state_r == sdh_pkg::SDH_WAIT_R)
        else $error("read wait not ended");
    a_done_flag: assert property (done |=> state_r == sdh_pkg::SDH_IDLE && sticky_r[8])
        else $error("data end missing");
    a_set_wins: assert property (wr_clr && reg_wdata[6] && rsp_ok |=> sticky_r[6])
        else $error("set lost to clear");
    a_clr_bit: assert property (wr_clr && reg_wdata[0] && !rsp_crc_fail |=> !sticky_r[0])
        else $error("flag not cleared");
    a_tmo_flag: assert property (tmo_hit |=> sticky_r[3] && state_r == sdh_pkg::SDH_IDLE)
        else $error("data timeout missing");
    a_dcnt_ro: assert property (reg_wr && reg_addr == 8'h0c && !start && !byte_strobe
        |=> $stable(byte_cnt_r))
        else $error("counter written");
    a_d2_drive: assert property (state_r == sdh_pkg::SDH_RDWAIT && !ctrl_r[10]
        |=> data_line_two_oe && !data_line_two_out ##1 !card_clock_hold)
        else $error("data line two not driven");
    c_tx_done: cover property (state_r == sdh_pkg::SDH_SEND ##[1:300] done);
    c_rx_done: cover property (state_r == sdh_pkg::SDH_RECV ##[1:300] done);
    c_rdwait: cover property (state_r == sdh_pkg::SDH_RDWAIT ##1 state_r == sdh_pkg::SDH_WAIT_R);
    c_timeout: cover property (tmo_hit);
endmodule
`default_nettype wire

// ==== design/sdh_pkg.sv ====
package sdh_pkg;
    typedef enum logic [5:0] {
        SDH_IDLE   = 6'h01,
        SDH_WAIT_S = 6'h02,
        SDH_SEND   = 6'h04,
        SDH_WAIT_R = 6'h08,
        SDH_RECV   = 6'h10,
        SDH_RDWAIT = 6'h20
    } sdh_state_t;
endpackage

// ==== verification/sdh_card_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sdh_card_model (
    // frame control
    input  wire logic       run,
    input  wire logic [3:0] start_mask,
    // card lines
    output logic            card_clk,
    output logic      [3:0] card_data
);
    // ==========================================
    // card clock, still outside frames
    initial begin
        card_clk  = 1'b0;
        card_data = 4'hf;
    end
    always begin
        #80;
        card_clk = run ? ~card_clk : 1'b0;
    end
    // ==========================================
    // lines pulled up unless a start bit is driven
    always @(negedge card_clk, start_mask) begin
        card_data <= ~start_mask;
    end
endmodule
`default_nettype wire

// ==== verification/sdh_data_ctrl_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sdh_cfg.svh"
module sdh_data_ctrl_tb;
    // ==========================================
    // signals
    logic        core_clk    = 1'b0;
    logic        reset_n     = 1'b0;
    logic [7:0]  reg_addr    = 8'h00;
    logic [31:0] reg_wdata   = 32'h0;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [31:0] ev          = 32'h0;
    logic        byte_strobe = 1'b0;
    logic        cmd_active  = 1'b0;
    logic        rsp_wait    = 1'b0;
    logic        run         = 1'b0;
    logic [5:0]  buf_level   = 6'h00;
    logic [3:0]  start_mask  = 4'h0;
    logic [3:0]  card_data_in;
    logic        card_clk_in;
    logic [31:0] reg_rdata;
    logic        dl2_out;
    logic        dl2_oe;
    logic        clk_hold;
    logic        dma_request;
    logic        card_io_mode;
    logic        xfer_active;
    logic        blk_end;
    logic [31:0] exp;
    int          fails       = 0;
    int          n_compared  = 0;
    int          cyc         = 0;
    int          n_blk       = 0;

    always #10 core_clk = ~core_clk;

    sdh_data_ctrl dut (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .card_clk_in(card_clk_in), .card_data_in(card_data_in),
        .data_line_two_out(dl2_out), .data_line_two_oe(dl2_oe), .card_clock_hold(clk_hold),
        .byte_strobe(byte_strobe), .word_strobe(1'b0), .buf_level(buf_level),
        .tx_underrun(ev[4]), .rx_overrun(ev[5]), .blk_crc_ok(ev[10]),
        .data_crc_fail(ev[1]), .block_end(blk_end), .dma_request(dma_request),
        .card_io_mode(card_io_mode), .xfer_active(xfer_active), .cmd_active(cmd_active),
        .rsp_wait(rsp_wait), .rsp_ok(ev[6]), .rsp_crc_fail(ev[0]), .cmd_sent(ev[7]),
        .card_irq(ev[22])
    );

    sdh_card_model card (
        .run(run), .start_mask(start_mask), .card_clk(card_clk_in), .card_data(card_data_in)
    );

    // ==========================================
    // tasks
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
        n_compared++;
        if (got !== e) begin
            $display("[ERR] %s expected %h seen %h", name, e, got);
            fails++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        repeat (7) @(posedge core_clk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk("reg_rdata", e, reg_rdata & m);
        @(posedge core_clk);
    endtask

    task automatic pulse(input logic [31:0] v);
        @(posedge core_clk);
        ev <= v;
        @(posedge core_clk);
        ev <= 32'h0;
    endtask

    task automatic cards(input int n);
        @(posedge core_clk);
        run <= 1'b1;
        repeat (n) @(posedge card_clk_in);
        @(posedge core_clk);
        run <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask

    task automatic bytes(input int n);
        repeat (n) begin
            @(posedge core_clk);
            byte_strobe <= 1'b1;
            @(posedge core_clk);
            byte_strobe <= 1'b0;
        end
    endtask

    task automatic wait_idle;
        int k = 0;
        while (xfer_active !== 1'b0 && k < 100) begin
            @(posedge core_clk);
            k++;
        end
        chk("xfer_active", 32'h0, {31'h0, xfer_active});
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (blk_end === 1'b1) begin
            n_blk++;
        end
        if (cyc == 30000) begin
            fails++;
            stop_test();
        end
    end

    // ==========================================
    // tests
    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdchk(`SDH_OFS_CTRL, 32'hffffffff, 32'h0);
        rdchk(`SDH_OFS_DCNT, 32'hffffffff, 32'h0);
        rdchk(`SDH_OFS_STS, 32'hffffffff, 32'h00044000);
        rdchk(`SDH_OFS_CLR, 32'hffffffff, 32'h0);
        rdchk(8'h20, 32'hffffffff, 32'h0);
        wr(`SDH_OFS_CTRL, 32'hfffff8f8);
        rdchk(`SDH_OFS_CTRL, 32'hffffffff, 32'h000008f8);
        chk("card_io_mode", 32'h1, {31'h0, card_io_mode});
        // sticky events, live command flag
        cmd_active <= 1'b1;
        pulse(32'h004004f3);
        rdchk(`SDH_OFS_STS, 32'h00400fff, 32'h00400cf3);
        cmd_active <= 1'b0;
        wr(`SDH_OFS_CLR, 32'h003ff800);
        rdchk(`SDH_OFS_STS, 32'h004007ff, 32'h004004f3);
        exp = 32'h004004f3;
        for (int i = 0; i < 23; i++) begin
            if (exp[i]) begin
                wr(`SDH_OFS_CLR, 32'h1 << i);
                exp[i] = 1'b0;
                rdchk(`SDH_OFS_STS, 32'h004007ff, exp);
            end
        end
        fork
            wr(`SDH_OFS_CLR, 32'h40);
            pulse(32'h40);
        join
        rdchk(`SDH_OFS_STS, 32'h40, 32'h40);
        wr(`SDH_OFS_CLR, 32'h40);
        wr(`SDH_OFS_CTRL, 32'h0);
        pulse(32'h00400000);
        rdchk(`SDH_OFS_STS, 32'h00400000, 32'h0);
        // response timeout at 64 card clocks
        @(posedge core_clk);
        rsp_wait <= 1'b1;
        cards(63);
        rdchk(`SDH_OFS_STS, 32'h4, 32'h0);
        cards(1);
        rdchk(`SDH_OFS_STS, 32'h4, 32'h4);
        rsp_wait <= 1'b0;
        wr(`SDH_OFS_CLR, 32'h4);
        // host to card block transfer with dma
        wr(`SDH_OFS_DLEN, 32'h3);
        wr(`SDH_OFS_CTRL, 32'h9);
        rdchk(`SDH_OFS_STS, 32'h3000, 32'h1000);
        rdchk(`SDH_OFS_BCNT, 32'hffffffff, 32'h1);
        buf_level <= 6'h04;
        repeat (3) @(posedge core_clk);
        rdchk(`SDH_OFS_STS, 32'h4000, 32'h4000);
        chk("dma_request", 32'h1, {31'h0, dma_request});
        bytes(2);
        repeat (3) @(posedge core_clk);
        chk("xfer_active", 32'h1, {31'h0, xfer_active});
        bytes(1);
        wait_idle();
        chk("block_end count", 32'h3, n_blk);
        rdchk(`SDH_OFS_STS, 32'h100, 32'h100);
        wr(`SDH_OFS_DCNT, 32'h55);
        rdchk(`SDH_OFS_DCNT, 32'hffffffff, 32'h0);
        repeat (20) @(posedge core_clk);
        chk("xfer_active", 32'h0, {31'h0, xfer_active});
        wr(`SDH_OFS_CLR, 32'h100);
        buf_level <= 6'h00;
        // card to host stream with read wait and start bit
        wr(`SDH_OFS_FLOW, 32'h2);
        wr(`SDH_OFS_DTMR, 32'h100);
        wr(`SDH_OFS_DLEN, 32'h2);
        wr(`SDH_OFS_CTRL, 32'h107);
        chk("oe hold out", 32'h4, {29'h0, dl2_oe, clk_hold, dl2_out});
        wr(`SDH_OFS_CTRL, 32'h306);
        chk("oe hold out", 32'h0, {29'h0, dl2_oe, clk_hold, dl2_out});
        rdchk(`SDH_OFS_STS, 32'h3000, 32'h2000);
        wr(`SDH_OFS_CTRL, 32'h406);
        chk("oe hold out", 32'h0, {29'h0, dl2_oe, clk_hold, dl2_out});
        wr(`SDH_OFS_CTRL, 32'h506);
        chk("oe hold out", 32'h1 << 1, {29'h0, dl2_oe, clk_hold, dl2_out});
        wr(`SDH_OFS_CTRL, 32'h406);
        start_mask <= 4'h1;
        cards(2);
        start_mask <= 4'h0;
        bytes(2);
        wait_idle();
        chk("block_end count", 32'h3, n_blk);
        rdchk(`SDH_OFS_STS, 32'h300, 32'h300);
        wr(`SDH_OFS_CLR, 32'h7ff);
        // data timeout while waiting to receive
        wr(`SDH_OFS_DTMR, 32'h3);
        wr(`SDH_OFS_CTRL, 32'h3);
        cards(3);
        rdchk(`SDH_OFS_STS, 32'h8, 32'h0);
        cards(1);
        rdchk(`SDH_OFS_STS, 32'h8, 32'h8);
        wait_idle();
        // flow control thresholds
        wr(`SDH_OFS_FLOW, 32'h1);
        buf_level <= 6'h1d;
        rdchk(`SDH_OFS_STS, 32'h20000, 32'h0);
        buf_level <= 6'h1e;
        rdchk(`SDH_OFS_STS, 32'h28000, 32'h28000);
        wr(`SDH_OFS_CTRL, 32'h0);
        buf_level <= 6'h03;
        rdchk(`SDH_OFS_STS, 32'h40000, 32'h0);
        buf_level <= 6'h02;
        rdchk(`SDH_OFS_STS, 32'h40000, 32'h40000);
        stop_test();
    end
endmodule
`default_nettype wire
